/* File: design/brto_bridge_order.sv */
// transaction ordering and posting core of a two-segment bridge
`timescale 1ns/10ps
module brto_bridge_order #(
  parameter int   ADDR_W       = 32,
  parameter int   DATA_W       = 32,
  parameter int   DEPTH        = brto_pkg::FIFO_DEPTH,
  parameter logic HOST_IO_POST = 1'b0
) (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic              a_in_valid_i,
  input  wire logic [2:0]        a_in_cmd_i,
  input  wire logic [ADDR_W-1:0] a_in_addr_i,
  input  wire logic [DATA_W-1:0] a_in_data_i,
  input  wire logic              a_in_lock_i,
  output logic                   a_in_done_o,
  output logic                   a_in_retry_o,
  output logic      [DATA_W-1:0] a_in_rdata_o,
  output logic                   a_out_valid_o,
  output logic      [2:0]        a_out_cmd_o,
  output logic      [ADDR_W-1:0] a_out_addr_o,
  output logic      [DATA_W-1:0] a_out_data_o,
  output logic                   a_out_lock_o,
  input  wire logic              a_out_done_i,
  input  wire logic              a_out_retry_i,
  input  wire logic [DATA_W-1:0] a_out_rdata_i,
  input  wire logic              a_lock_est_i,
  input  wire logic              b_in_valid_i,
  input  wire logic [2:0]        b_in_cmd_i,
  input  wire logic [ADDR_W-1:0] b_in_addr_i,
  input  wire logic [DATA_W-1:0] b_in_data_i,
  input  wire logic              b_in_lock_i,
  output logic                   b_in_done_o,
  output logic                   b_in_retry_o,
  output logic      [DATA_W-1:0] b_in_rdata_o,
  output logic                   b_out_valid_o,
  output logic      [2:0]        b_out_cmd_o,
  output logic      [ADDR_W-1:0] b_out_addr_o,
  output logic      [DATA_W-1:0] b_out_data_o,
  output logic                   b_out_lock_o,
  input  wire logic              b_out_done_i,
  input  wire logic              b_out_retry_i,
  input  wire logic [DATA_W-1:0] b_out_rdata_i,
  input  wire logic              b_lock_est_i
);
  localparam int QW = ADDR_W + DATA_W + brto_pkg::CMD_W;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  // direction d enters on side d and is mastered on the other side
  logic              in_valid [2];
  logic [2:0]        in_cmd   [2];
  logic [ADDR_W-1:0] in_addr  [2];
  logic [DATA_W-1:0] in_data  [2];
  logic              in_lock  [2];
  logic              lock_est [2];
  logic              mst_done [2];
  logic              mst_retry[2];
  logic [DATA_W-1:0] mst_rdata[2];

  logic              in_done  [2];
  logic              in_retry [2];
  logic [DATA_W-1:0] in_rdata [2];
  logic              mst_valid[2];
  logic [2:0]        mst_cmd  [2];
  logic [ADDR_W-1:0] mst_addr [2];
  logic [DATA_W-1:0] mst_data [2];
  logic              mst_lock [2];
  logic              own_wr   [2];
  logic              own_slot [2];

  brto_pkg::brto_slot_type slot_st[2];
  logic [2:0]        slot_cmd  [2];
  logic [ADDR_W-1:0] slot_addr [2];
  logic [DATA_W-1:0] slot_data [2];
  logic [DATA_W-1:0] slot_rdata[2];
  logic              slot_lock [2];
  logic [brto_pkg::SEQ_W-1:0] push_tag[2];
  logic [brto_pkg::SEQ_W-1:0] pull_tag[2];
  logic [brto_pkg::SEQ_W-1:0] wr_seq  [2];
  logic [brto_pkg::SEQ_W-1:0] done_seq[2];

  logic          wr_post   [2];
  logic          np_req    [2];
  logic          lock_block[2];
  logic          push_ok   [2];
  logic          q_ready   [2];
  logic          q_valid   [2];
  logic [QW-1:0] q_head    [2];
  logic          load_wr   [2];
  logic          load_slot [2];
  logic          slot_hit  [2];

  // port mapping: index 0 is side a entry, mastered on side b
  assign in_valid  = '{a_in_valid_i, b_in_valid_i};
  assign in_cmd    = '{a_in_cmd_i, b_in_cmd_i};
  assign in_addr   = '{a_in_addr_i, b_in_addr_i};
  assign in_data   = '{a_in_data_i, b_in_data_i};
  assign in_lock   = '{a_in_lock_i, b_in_lock_i};
  assign lock_est  = '{a_lock_est_i, b_lock_est_i};
  assign mst_done  = '{b_out_done_i, a_out_done_i};
  assign mst_retry = '{b_out_retry_i, a_out_retry_i};
  assign mst_rdata = '{b_out_rdata_i, a_out_rdata_i};

  assign a_in_done_o   = in_done[0];
  assign a_in_retry_o  = in_retry[0];
  assign a_in_rdata_o  = in_rdata[0];
  assign b_in_done_o   = in_done[1];
  assign b_in_retry_o  = in_retry[1];
  assign b_in_rdata_o  = in_rdata[1];
  assign b_out_valid_o = mst_valid[0];
  assign b_out_cmd_o   = mst_cmd[0];
  assign b_out_addr_o  = mst_addr[0];
  assign b_out_data_o  = mst_data[0];
  assign b_out_lock_o  = mst_lock[0];
  assign a_out_valid_o = mst_valid[1];
  assign a_out_cmd_o   = mst_cmd[1];
  assign a_out_addr_o  = mst_addr[1];
  assign a_out_data_o  = mst_data[1];
  assign a_out_lock_o  = mst_lock[1];

  // each direction has its own queue, slot and master; only the read pull and the lock hold depend on the other
  for (genvar d = 0; d < 2; d++) begin : g_dir
    localparam int O = 1 - d;

    // request classification at the entry side
    assign wr_post[d] = in_valid[d] && brto_pkg::is_posted(in_cmd[d], HOST_IO_POST);
    assign np_req[d]  = in_valid[d] && !brto_pkg::is_posted(in_cmd[d], HOST_IO_POST);
    // the master on this entry side belongs to direction O
    assign lock_block[d] = lock_est[d] && slot_lock[O] && (slot_st[O] == brto_pkg::SLOT_ISSUE);
    // acceptance depends only on queue room and an established lock
    assign push_ok[d] = wr_post[d] && q_ready[d] && !lock_block[d];
    assign slot_hit[d] = np_req[d] && (slot_st[d] == brto_pkg::SLOT_READY) &&
                         (in_cmd[d] == slot_cmd[d]) && (in_addr[d] == slot_addr[d]) &&
                         (in_data[d] == slot_data[d]);

    // posted-write queue, order kept by first-in first-out
    brto_fifo #(
      .WIDTH (QW),
      .DEPTH (DEPTH)
    ) u_queue (
      .sys_clk_i    (sys_clk_i),
      .reset_i      (reset_i),
      .push_valid_i (push_ok[d]),
      .push_ready_o (q_ready[d]),
      .push_data_i  ({in_cmd[d], in_addr[d], in_data[d]}),
      .pop_valid_o  (q_valid[d]),
      .pop_ready_i  (load_wr[d]),
      .pop_data_o   (q_head[d])
    );

    // target answers one cycle after the attempt
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
        in_done[d]  <= 1'b0;
        in_retry[d] <= 1'b0;
        in_rdata[d] <= '0;
      end else begin
        in_done[d]  <= push_ok[d] || slot_hit[d];
        in_retry[d] <= (wr_post[d] && !push_ok[d]) || (np_req[d] && !slot_hit[d]);
        if (slot_hit[d]) begin
          in_rdata[d] <= slot_rdata[d];
        end
      end
    end

    // acceptance and completion tags for flush comparisons
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
        wr_seq[d]   <= brto_pkg::SEQ_RST;
        done_seq[d] <= brto_pkg::SEQ_RST;
      end else begin
        if (push_ok[d]) begin
          wr_seq[d] <= wr_seq[d] + brto_pkg::SEQ_ONE;
        end
        if (mst_done[d] && own_wr[d]) begin
          done_seq[d] <= done_seq[d] + brto_pkg::SEQ_ONE;
        end
      end
    end

    // non-posted slot: flush, issue, pull for reads, then wait for the reissue
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
        slot_st[d]    <= brto_pkg::SLOT_IDLE;
        slot_cmd[d]   <= brto_pkg::CMD_MEM_RD;
        slot_addr[d]  <= '0;
        slot_data[d]  <= '0;
        slot_lock[d]  <= 1'b0;
        slot_rdata[d] <= '0;
        push_tag[d]   <= brto_pkg::SEQ_RST;
        pull_tag[d]   <= brto_pkg::SEQ_RST;
      end else begin
        case (slot_st[d])
          brto_pkg::SLOT_IDLE: begin
            if (np_req[d]) begin
              slot_cmd[d]  <= in_cmd[d];
              slot_addr[d] <= in_addr[d];
              slot_data[d] <= in_data[d];
              slot_lock[d] <= in_lock[d];
              push_tag[d]  <= wr_seq[d];
              slot_st[d]   <= brto_pkg::SLOT_FLUSH;
            end
          end
          brto_pkg::SLOT_FLUSH: begin
            if (done_seq[d] == push_tag[d]) begin
              slot_st[d] <= brto_pkg::SLOT_ISSUE;
            end
          end
          brto_pkg::SLOT_ISSUE: begin
            if (mst_done[d] && own_slot[d]) begin
              slot_rdata[d] <= mst_rdata[d];
              pull_tag[d]   <= wr_seq[O];
              slot_st[d]    <= brto_pkg::is_read(slot_cmd[d]) ?
                               brto_pkg::SLOT_PULL : brto_pkg::SLOT_READY;
            end
          end
          brto_pkg::SLOT_PULL: begin
            if (done_seq[O] == pull_tag[d]) begin
              slot_st[d] <= brto_pkg::SLOT_READY;
            end
          end
          brto_pkg::SLOT_READY: begin
            if (slot_hit[d]) begin
              slot_st[d] <= brto_pkg::SLOT_IDLE;
            end
          end
          default: slot_st[d] <= brto_pkg::SLOT_IDLE;
        endcase
      end
    end

    // destination master: posted writes first, then the slot request
    assign load_wr[d]   = !own_wr[d] && !own_slot[d] && q_valid[d];
    assign load_slot[d] = !own_wr[d] && !own_slot[d] && !q_valid[d] &&
                          (slot_st[d] == brto_pkg::SLOT_ISSUE);

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
        own_wr[d]    <= 1'b0;
        own_slot[d]  <= 1'b0;
        mst_valid[d] <= 1'b0;
        mst_cmd[d]   <= brto_pkg::CMD_MEM_RD;
        mst_addr[d]  <= '0;
        mst_data[d]  <= '0;
        mst_lock[d]  <= 1'b0;
      end else if (load_wr[d]) begin
        own_wr[d]    <= 1'b1;
        mst_valid[d] <= 1'b1;
        {mst_cmd[d], mst_addr[d], mst_data[d]} <= q_head[d];
        mst_lock[d]  <= 1'b0;
      end else if (load_slot[d]) begin
        own_slot[d]  <= 1'b1;
        mst_valid[d] <= 1'b1;
        mst_cmd[d]   <= slot_cmd[d];
        mst_addr[d]  <= slot_addr[d];
        mst_data[d]  <= slot_data[d];
        mst_lock[d]  <= slot_lock[d];
      end else if (mst_done[d]) begin
        own_wr[d]    <= 1'b0;
        own_slot[d]  <= 1'b0;
        mst_valid[d] <= 1'b0;
      end else if (mst_retry[d]) begin
        mst_valid[d] <= 1'b0;
      end else if (own_wr[d] || own_slot[d]) begin
        mst_valid[d] <= 1'b1;
      end
    end

    // checks on ordering and posting
    a_io_write_held: assert property (
      (in_valid[d] && (in_cmd[d] == brto_pkg::CMD_IO_WR) && !HOST_IO_POST) |-> !push_ok[d])
      else $error("io write was posted");
    a_read_not_posted: assert property (
      (in_valid[d] && brto_pkg::is_read(in_cmd[d])) |->
      !push_ok[d] ##1 (!in_done[d] || $past(slot_hit[d])))
      else $error("read posted or completed early");
    a_mem_write_posted: assert property (
      (in_valid[d] && (in_cmd[d] == brto_pkg::CMD_MEM_WR) && q_ready[d] && !lock_block[d])
      |=> in_done[d] && !in_retry[d])
      else $error("memory write with room not posted");
    a_master_no_wait: assert property (
      (wr_post[d] && mst_valid[O] && q_ready[d] && !lock_est[d]) |=> in_done[d])
      else $error("write acceptance waited on master");
    a_full_refused: assert property (
      (wr_post[d] && !q_ready[d]) |=> in_retry[d] && !in_done[d])
      else $error("write to full queue not retried");
    a_push_flush: assert property (
      load_slot[d] |-> !q_valid[d] && // writes taken after the read may pass it
      ((done_seq[d] - push_tag[d]) <= (wr_seq[d] - push_tag[d])))
      else $error("request issued before earlier writes");
    a_pull_flush: assert property (
      (slot_hit[d] && brto_pkg::is_read(slot_cmd[d])) |->
      ((done_seq[O] - pull_tag[d]) <= (wr_seq[O] - pull_tag[d])))
      else $error("read completed before opposite writes");
    a_retry_pending: assert property (
      (np_req[d] && (slot_st[d] != brto_pkg::SLOT_READY)) |=> in_retry[d])
      else $error("pending request not retried");
    a_write_order: assert property (
      (mst_done[d] && own_wr[d]) |=> done_seq[d] == $past(done_seq[d]) + brto_pkg::SEQ_ONE)
      else $error("posted write completion miscounted");
    c_write_posted: cover property (push_ok[d] ##1 in_done[d]);
    c_read_done: cover property (slot_hit[d] && brto_pkg::is_read(slot_cmd[d]));
    c_flush_wait: cover property ((slot_st[d] == brto_pkg::SLOT_FLUSH) ##1
                                  (slot_st[d] == brto_pkg::SLOT_FLUSH));
    c_full_retry: cover property (wr_post[d] && !q_ready[d]);
    c_lock_hold: cover property (wr_post[d] && lock_block[d]);
  end
endmodule

/* File: design/brto_pkg.sv */
// shared constants, types and decode helpers for the bridge ordering core
package brto_pkg;

  // bus command encodings seen at both segment ports
  localparam int         CMD_W      = 3;
  localparam logic [2:0] CMD_MEM_RD = 3'h0;
  localparam logic [2:0] CMD_MEM_WR = 3'h1;
  localparam logic [2:0] CMD_IO_RD  = 3'h2;
  localparam logic [2:0] CMD_IO_WR  = 3'h3;
  localparam logic [2:0] CMD_CFG_RD = 3'h4;
  localparam logic [2:0] CMD_CFG_WR = 3'h5;

  // acceptance-order tags for posted writes
  localparam int         SEQ_W   = 8;
  localparam logic [7:0] SEQ_RST = 8'h00;
  localparam logic [7:0] SEQ_ONE = 8'h01;

  // default posted-write queue depth per direction
  localparam int FIFO_DEPTH = 4;

  // non-posted transaction slot, one per direction
  typedef enum logic [2:0] {
    SLOT_IDLE,
    SLOT_FLUSH,
    SLOT_ISSUE,
    SLOT_PULL,
    SLOT_READY
  } brto_slot_type;

  // any read, whatever the space
  function automatic logic is_read(input logic [2:0] cmd);
    is_read = (cmd == CMD_MEM_RD) || (cmd == CMD_IO_RD) || (cmd == CMD_CFG_RD);
  endfunction

  // commands the bridge completes at the source before the destination
  function automatic logic is_posted(input logic [2:0] cmd, input logic host_io);
    is_posted = (cmd == CMD_MEM_WR) || (host_io && (cmd == CMD_IO_WR));
  endfunction

endpackage

/* File: design/brto_fifo.sv */
// first-in first-out posted-write queue with valid/ready on both sides
`timescale 1ns/10ps
module brto_fifo #(
  parameter int WIDTH = 67,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic             push_valid_i,
  output logic                  push_ready_o,
  input  wire logic [WIDTH-1:0] push_data_i,
  output logic                  pop_valid_o,
  input  wire logic             pop_ready_i,
  output logic      [WIDTH-1:0] pop_data_o
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic             push_fire;
  logic             pop_fire;

  // honest full and empty from the occupancy count
  assign push_ready_o = (count != CNT_FULL);
  assign pop_valid_o  = (count != '0);
  assign pop_data_o   = mem[rd_ptr];
  assign push_fire    = push_valid_i && push_ready_o;
  assign pop_fire     = pop_ready_i && pop_valid_o;

  // storage write
  always_ff @(posedge sys_clk_i) begin
    if (push_fire) begin
      mem[wr_ptr] <= push_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push_fire) begin
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop_fire) begin
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (push_fire && !pop_fire) begin
        count <= count + 1'b1;
      end else if (pop_fire && !push_fire) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

/* File: bench/brto_seg_model.sv */
// behavioural target standing on one outgoing bridge segment
`timescale 1ns/10ps
module brto_seg_model (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic        valid_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [7:0]  lat_i,
  input  wire logic        rty_i,
  output logic             done_o,
  output logic             retry_o,
  output logic      [31:0] rdata_o
);
  logic [7:0] cnt;
  logic       tried;

  // answer after lat_i cycles, retrying each transfer once if asked
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt     <= 8'h00;
      tried   <= 1'b0;
      done_o  <= 1'b0;
      retry_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
    end else begin
      done_o  <= 1'b0;
      retry_o <= 1'b0;
      rdata_o <= ~rdata_o;  // no valid data between completions
      if (valid_i && !done_o && !retry_o) begin
        cnt <= cnt + 8'h01;
        if (cnt >= lat_i) begin
          cnt <= 8'h00;
          if (rty_i && !tried) begin
            retry_o <= 1'b1;
            tried   <= 1'b1;
          end else begin
            done_o  <= 1'b1;
            tried   <= 1'b0;
            rdata_o <= ~addr_i;
          end
        end
      end
    end
  end
endmodule

/* File: bench/test_brto_bridge_order.sv */
// self-checking bench for the bridge ordering core
`timescale 1ns/10ps
module test_brto_bridge_order;
  localparam logic [2:0] WR = brto_pkg::CMD_MEM_WR;
  localparam logic [2:0] RD = brto_pkg::CMD_MEM_RD;
  localparam logic [2:0] NP [5] = '{brto_pkg::CMD_IO_WR, brto_pkg::CMD_CFG_WR,
    brto_pkg::CMD_MEM_RD, brto_pkg::CMD_IO_RD, brto_pkg::CMD_CFG_RD};
  logic        sys_clk_i;
  logic        reset_i;
  logic [1:0]  iv, il, lest, rty, idn, irt, ov, ol, odn, ort;
  logic [2:0]  ic [2];
  logic [2:0]  oc [2];
  logic [31:0] ia [2];
  logic [31:0] idt [2];
  logic [31:0] ird [2];
  logic [31:0] oa [2];
  logic [31:0] od [2];
  logic [31:0] ord [2];
  logic [7:0]  lat [2];
  logic [31:0] log_a [2][$];
  logic [31:0] log_d [2][$];
  logic [2:0]  log_c [2][$];
  int          n_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  brto_bridge_order DUT (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .a_in_valid_i(iv[0]), .a_in_cmd_i(ic[0]), .a_in_addr_i(ia[0]), .a_in_data_i(idt[0]),
    .a_in_lock_i(il[0]), .a_in_done_o(idn[0]), .a_in_retry_o(irt[0]), .a_in_rdata_o(ird[0]),
    .a_out_valid_o(ov[0]), .a_out_cmd_o(oc[0]), .a_out_addr_o(oa[0]), .a_out_data_o(od[0]),
    .a_out_lock_o(ol[0]), .a_out_done_i(odn[0]), .a_out_retry_i(ort[0]),
    .a_out_rdata_i(ord[0]), .a_lock_est_i(lest[0]),
    .b_in_valid_i(iv[1]), .b_in_cmd_i(ic[1]), .b_in_addr_i(ia[1]), .b_in_data_i(idt[1]),
    .b_in_lock_i(il[1]), .b_in_done_o(idn[1]), .b_in_retry_o(irt[1]), .b_in_rdata_o(ird[1]),
    .b_out_valid_o(ov[1]), .b_out_cmd_o(oc[1]), .b_out_addr_o(oa[1]), .b_out_data_o(od[1]),
    .b_out_lock_o(ol[1]), .b_out_done_i(odn[1]), .b_out_retry_i(ort[1]),
    .b_out_rdata_i(ord[1]), .b_lock_est_i(lest[1]));

  // one target model per segment
  for (genvar s = 0; s < 2; s++) begin : g_seg
    brto_seg_model SEG (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .valid_i(ov[s]),
      .addr_i(oa[s]), .lat_i(lat[s]), .rty_i(rty[s]), .done_o(odn[s]),
      .retry_o(ort[s]), .rdata_o(ord[s]));
  end

  // clock at 40 MHz
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // record every transfer completed on each segment
  always @(posedge sys_clk_i) begin
    for (int k = 0; k < 2; k++) begin
      if (odn[k] === 1'b1 && ov[k] === 1'b1) begin
        log_a[k].push_back(oa[k]);
        log_d[k].push_back(od[k]);
        log_c[k].push_back(oc[k]);
      end
    end
  end

  // hang guard
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task test_done();
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one target attempt on side s, answer sampled the cycle after
  task attempt(input int s, input logic [2:0] c, input logic [31:0] a,
               output logic dn, output logic rt);
    @(posedge sys_clk_i);
    iv[s]  <= 1'b1;
    ic[s]  <= c;
    ia[s]  <= a;
    idt[s] <= a ^ 32'h5A5A_5A5A;
    @(posedge sys_clk_i);
    iv[s] <= 1'b0;
    #1;
    dn = idn[s];
    rt = irt[s];
    chk(dn ^ rt, 1'b1, "not one answer");
  endtask

  // a master that waits for completion, reissuing identically
  task xfer(input int s, input logic [2:0] c, input logic [31:0] a, output int n);
    logic dn, rt;
    n = 0;
    dn = 1'b0;
    while (dn !== 1'b1 && n < 200) begin
      attempt(s, c, a, dn, rt);
      n++;
    end
    chk(dn, 1'b1, "never completed");
  endtask

  task wait_log(input int k, input int n);
    for (int t = 0; t < 500 && log_a[k].size() < n; t++) begin
      @(posedge sys_clk_i);
    end
    #1;
  endtask

  // next transfer completed on segment k
  task expect_out(input int k, input logic [2:0] c, input logic [31:0] a);
    if (log_a[k].size() == 0) begin
      chk(32'h0, 32'h1, "missing transfer");
    end else begin
      chk(log_c[k].pop_front(), c, "cmd");
      chk(log_a[k].pop_front(), a, "addr");
      chk(log_d[k].pop_front(), a ^ 32'h5A5A_5A5A, "data");
    end
  endtask

  // posted writes finish at once, leave in order despite a target retry
  task t_post();
    logic dn, rt;
    lat[1] <= 8'h05;
    rty[1] <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      attempt(0, WR, 32'h0000_0100 + 4 * i, dn, rt);
      chk(dn, 1'b1, "write not posted");
    end
    wait_log(1, 3);
    for (int i = 0; i < 3; i++) begin
      expect_out(1, WR, 32'h0000_0100 + 4 * i);
    end
    rty[1] <= 1'b0;
  endtask

  // fill the queue until refused, then drain and post again
  task t_full();
    logic dn, rt;
    int   acc;
    int   n;
    acc = 0;
    rt = 1'b0;
    lat[1] <= 8'h3C;
    for (int i = 0; i < 8 && rt !== 1'b1; i++) begin
      attempt(0, WR, 32'h0000_1000 + 4 * i, dn, rt);
      if (dn === 1'b1) begin
        acc++;
      end
    end
    chk(rt, 1'b1, "full queue not refused");
    chk(acc >= brto_pkg::FIFO_DEPTH, 1'b1, "refused early");
    lat[1] <= 8'h00;
    xfer(0, WR, 32'h0000_1000 + 4 * acc, n);
    wait_log(1, acc + 1);
    for (int i = 0; i <= acc; i++) begin
      expect_out(1, WR, 32'h0000_1000 + 4 * i);
    end
  endtask

  // every non-posted command is retried first and finishes at the far side first
  task t_nonpost();
    logic dn, rt;
    int   n;
    lat[0] <= 8'h03;
    for (int i = 0; i < 5; i++) begin
      attempt(1, NP[i], 32'h0000_2000 + 16 * i, dn, rt);
      chk(rt, 1'b1, "non-posted accepted");
      xfer(1, NP[i], 32'h0000_2000 + 16 * i, n);
      chk(log_a[0].size(), 1, "done before destination");
      expect_out(0, NP[i], 32'h0000_2000 + 16 * i);
      if (i >= 2) begin
        chk(ird[1], ~(32'h0000_2000 + 16 * i), "read data");
      end
    end
  endtask

  // a read pushes earlier same-side writes ahead of it
  task t_push();
    logic dn, rt;
    int   n;
    lat[1] <= 8'h0A;
    attempt(0, WR, 32'h0000_0300, dn, rt);
    attempt(0, WR, 32'h0000_0304, dn, rt);
    xfer(0, RD, 32'h0000_0400, n);
    chk(n > 2, 1'b1, "read not retried while flushing");
    chk(ird[0], ~32'h0000_0400, "read data");
    expect_out(1, WR, 32'h0000_0300);
    expect_out(1, WR, 32'h0000_0304);
    expect_out(1, RD, 32'h0000_0400);
  endtask

  // a read pulls opposite writes; directions and acceptance independent
  task t_pull();
    logic dn, rt;
    int   n;
    lat[0] <= 8'h28;
    lat[1] <= 8'h00;
    attempt(1, WR, 32'h0000_0500, dn, rt);
    repeat (4) @(posedge sys_clk_i);
    attempt(0, WR, 32'h0000_0600, dn, rt);
    chk(dn, 1'b1, "write waits on busy master");
    wait_log(1, 1);
    chk(log_a[0].size(), 0, "directions coupled");
    xfer(0, RD, 32'h0000_0700, n);
    chk(log_a[0].size(), 1, "read done before pull");
    chk(ird[0], ~32'h0000_0700, "read data");
    expect_out(1, WR, 32'h0000_0600);
    expect_out(1, RD, 32'h0000_0700);
    expect_out(0, WR, 32'h0000_0500);
  endtask

  // a locked request mastered on side a may hold writes entering there
  task t_lock();
    logic dn, rt;
    int   n;
    @(posedge sys_clk_i);
    il[1] <= 1'b1;
    attempt(1, RD, 32'h0000_0800, dn, rt);
    @(posedge sys_clk_i);
    il[1]   <= 1'b0;
    lest[0] <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk(ol[0], 1'b1, "lock not presented");
    attempt(0, WR, 32'h0000_0900, dn, rt);
    chk(rt, 1'b1, "write taken under lock");
    @(posedge sys_clk_i);
    lest[0] <= 1'b0;
    attempt(0, WR, 32'h0000_0900, dn, rt);
    chk(dn, 1'b1, "write refused without lock");
    xfer(1, RD, 32'h0000_0800, n);
    chk(ird[1], ~32'h0000_0800, "read data");
    expect_out(1, WR, 32'h0000_0900);
    expect_out(0, RD, 32'h0000_0800);
  endtask

  initial begin
    reset_i = 1'b1;
    iv = 2'b00;
    il = 2'b00;
    lest = 2'b00;
    rty = 2'b00;
    for (int k = 0; k < 2; k++) begin
      ic[k] = 3'h0;
      ia[k] = 32'h0000_0000;
      idt[k] = 32'h0000_0000;
      lat[k] = 8'h00;
    end
    repeat (19) @(posedge sys_clk_i);
    #1;
    chk({idn, irt, ov}, 6'h00, "outputs in reset");
    @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk({idn, irt, ov}, 6'h00, "outputs after reset");
    t_post();
    t_full();
    t_nonpost();
    t_push();
    t_pull();
    t_lock();
    test_done();
  end
endmodule
